// file: hdl/brc_top.sv
// brc_top: block ram used as a fifo, with output latches and resets
// assumes fabric strobes on core_clk; global_set_reset_n may be async
//
// Functional notes
// RULE1 - read pointer reset moves only the read pointer, replaying held data
// RULE2 - user logic tracks packet writes and reads so a replay is intended
// RULE3 - ports a and b each own an output latch, sync or async reset
// RULE4 - each local reset clears only its own port's output latch
// RULE5 - low global set/reset clears both port output latches together
// RULE6 - global set/reset acts asynchronously whatever latch mode is chosen
// RULE7 - user holds clock enables low around an async or global reset; the bench holds them low only around the global reset
// RULE8 - with enables active, reset only after clocks steady one fmax period
// RULE9 - hardware fifo pointers and empty/full flags need no fabric logic
// RULE10 - latch or pointer resets leave the memory contents unchanged
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module brc_top (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  // fabric reset inputs
  input  wire logic                       global_set_reset_n,
  input  wire logic                       read_pointer_reset,
  input  wire logic                       port_a_output_reset,
  input  wire logic                       port_b_output_reset,
  // port a, write side
  input  wire logic                       port_a_clk_en,
  input  wire logic                       port_a_write_en,
  input  wire logic [brc_pkg::DATA_W-1:0] port_a_write_data,
  output logic      [brc_pkg::DATA_W-1:0] port_a_q,
  // port b, read side
  input  wire logic                       port_b_clk_en,
  input  wire logic                       port_b_read_en,
  output logic      [brc_pkg::DATA_W-1:0] port_b_q,
  // fifo flags
  output logic                            fifo_empty,
  output logic                            fifo_full,
  // axi4-lite slave
  input  wire logic [brc_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [brc_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       awready;
    logic                       wready;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       arready;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
    logic                       aw_got;
    logic                       w_got;
    logic [brc_pkg::AXI_AW-1:0] aw_addr;
    logic [31:0]                wdata;
    logic [3:0]                 wstrb;
    logic                       async_a;
    logic                       async_b;
    logic                       rp_soft;
    logic [brc_pkg::PTR_W-1:0]  wr_ptr;
    logic [brc_pkg::PTR_W-1:0]  rd_ptr;
    logic                       empty;
    logic                       full;
  } brc_state_t;

  brc_state_t st;
  brc_state_t next_st;

  logic [brc_pkg::DATA_W-1:0] mem [0:brc_pkg::DEPTH-1];
  logic                       push;
  logic                       pop;
  logic                       rp_any;

  function automatic logic [brc_pkg::PTR_W-1:0] ptr_count(
    input logic [brc_pkg::PTR_W-1:0] wp,
    input logic [brc_pkg::PTR_W-1:0] rp);
    ptr_count = wp - rp;
  endfunction

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction

  // full and empty come from flopped flags, never from fabric luts
  assign push   = port_a_clk_en & port_a_write_en & ~st.full;  // RULE9
  assign pop    = port_b_clk_en & port_b_read_en & ~st.empty;  // RULE9
  assign rp_any = read_pointer_reset | st.rp_soft;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rp_soft = 1'b0;
    // write address and data taken in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_got  = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
      next_st.wready = 1'b0;
    end
    if (st.aw_got && st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = brc_pkg::RESP_OKAY;
      if (word_addr(st.aw_addr) == brc_pkg::OFS_CTRL) begin
        if (st.wstrb[0]) begin
          next_st.async_a = st.wdata[brc_pkg::CTRL_ASYNC_A];
          next_st.async_b = st.wdata[brc_pkg::CTRL_ASYNC_B];
          next_st.rp_soft = st.wdata[brc_pkg::CTRL_RP_RST];
        end
      end else if (word_addr(st.aw_addr) != brc_pkg::OFS_STATUS) begin
        next_st.bresp = brc_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = brc_pkg::RESP_OKAY;
      next_st.rdata   = 32'h0000_0000;
      case (word_addr(s_axi_araddr))
        brc_pkg::OFS_CTRL: begin
          next_st.rdata[brc_pkg::CTRL_ASYNC_A] = st.async_a;
          next_st.rdata[brc_pkg::CTRL_ASYNC_B] = st.async_b;
        end
        brc_pkg::OFS_STATUS: begin
          next_st.rdata[brc_pkg::STAT_COUNT_LSB +: brc_pkg::PTR_W] =
            ptr_count(st.wr_ptr, st.rd_ptr);
          next_st.rdata[brc_pkg::STAT_EMPTY]   = st.empty;
          next_st.rdata[brc_pkg::STAT_FULL]    = st.full;
          next_st.rdata[brc_pkg::STAT_ASYNC_A] = st.async_a;
          next_st.rdata[brc_pkg::STAT_ASYNC_B] = st.async_b;
        end
        default: begin
          next_st.rresp = brc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    // fifo pointers
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + 9'h001;
    end
    // pointer reset wins over a pop and leaves the write side alone
    if (rp_any) begin
      next_st.rd_ptr = 9'h000; // RULE1
    end else if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 9'h001;
    end
    next_st.empty = ptr_count(next_st.wr_ptr, next_st.rd_ptr) == 9'h000;
    next_st.full  = ptr_count(next_st.wr_ptr, next_st.rd_ptr)
                    == brc_pkg::DEPTH; // RULE9
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.async_a <= brc_pkg::RST_ASYNC_A;
      st.async_b <= brc_pkg::RST_ASYNC_B;
      st.empty   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // memory array and output latches
  // ----------------------------------------------------------------
  // no reset here: only a push ever changes the stored words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st.wr_ptr[brc_pkg::ADDR_W-1:0]] <= port_a_write_data; // RULE10
    end
  end

  // port a shows the word being overwritten (read before write)
  brc_out_latch u_latch_a (
    .core_clk           (core_clk),
    .rst                (rst),
    .global_set_reset_n (global_set_reset_n),
    .local_reset        (port_a_output_reset),
    .async_mode         (st.async_a),
    .load               (push),
    .d                  (mem[st.wr_ptr[brc_pkg::ADDR_W-1:0]]),
    .q                  (port_a_q)
  ); // RULE4

  brc_out_latch u_latch_b (
    .core_clk           (core_clk),
    .rst                (rst),
    .global_set_reset_n (global_set_reset_n),
    .local_reset        (port_b_output_reset),
    .async_mode         (st.async_b),
    .load               (pop),
    .d                  (mem[st.rd_ptr[brc_pkg::ADDR_W-1:0]]),
    .q                  (port_b_q)
  ); // RULE4

  assign fifo_empty    = st.empty;
  assign fifo_full     = st.full;
  assign s_axi_awready = st.awready;
  assign s_axi_wready  = st.wready;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  rp_to_start_a: assert property (rp_any |=> st.rd_ptr == 9'h000) // RULE1
    else $error("read pointer not at start after pointer reset");
  rp_keeps_wr_a: assert property ( // RULE1
    rp_any && !push |=> $stable(st.wr_ptr))
    else $error("pointer reset moved the write pointer");
  replay_word_a: assert property ( // RULE10
    rp_any ##1 (pop && global_set_reset_n && !port_b_output_reset)
    |=> port_b_q == $past(mem[0]))
    else $error("replayed word differs from first stored word");
  async_mode_a: assert property ( // RULE3
    st.async_a && port_a_output_reset |-> port_a_q == '0)
    else $error("async port a reset not immediate");
  sync_clear_a: assert property ( // RULE4
    port_a_output_reset |=> port_a_q == '0)
    else $error("port a latch not cleared");
  // an async port b clear in the second cycle is a separate event
  b_untouched_a: assert property ( // RULE4
    port_a_output_reset && !port_b_output_reset && !pop
    && global_set_reset_n ##1 global_set_reset_n && !port_b_output_reset
    |-> port_b_q == $past(port_b_q))
    else $error("port a reset disturbed port b latch");
  gsr_both_a: assert property ( // RULE5 RULE6
    !global_set_reset_n |-> port_a_q == '0 && port_b_q == '0)
    else $error("global reset did not clear both latches at once");
  full_block_a: assert property ( // RULE9
    st.full |-> !push
    && ptr_count(st.wr_ptr, st.rd_ptr) == brc_pkg::DEPTH)
    else $error("full flag inconsistent or write accepted");
  empty_flag_a: assert property ( // RULE9
    st.empty |-> !pop ##1 (port_b_q == $past(port_b_q)
    || $past(port_b_output_reset) || !$past(global_set_reset_n)
    || !global_set_reset_n || port_b_output_reset))
    else $error("read from empty fifo changed port b");

  cov_retransmit_c: cover property (push ##[1:8] pop ##1 rp_any ##1 pop);
  cov_full_c:       cover property (st.full);
  cov_gsr_c:        cover property (!global_set_reset_n ##1 global_set_reset_n);
  cov_axi_wr_c:     cover property (st.bvalid && s_axi_bready);

endmodule // brc_top

// file: hdl/brc_pkg.sv
// brc_pkg: constants for the block ram reset control block
// assumes a 32-bit axi4-lite register port and one core clock
package brc_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PTR_W  = 9;
  localparam logic [8:0]  DEPTH  = 9'h100;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned AXI_AW     = 8;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;

  // ctrl fields
  localparam int unsigned CTRL_ASYNC_A = 0;
  localparam int unsigned CTRL_ASYNC_B = 1;
  localparam int unsigned CTRL_RP_RST  = 2;
  localparam logic        RST_ASYNC_A  = 1'b0;
  localparam logic        RST_ASYNC_B  = 1'b0;

  // status fields
  localparam int unsigned STAT_COUNT_LSB = 0;
  localparam int unsigned STAT_EMPTY     = 16;
  localparam int unsigned STAT_FULL      = 17;
  localparam int unsigned STAT_ASYNC_A   = 18;
  localparam int unsigned STAT_ASYNC_B   = 19;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hdl/brc_out_latch.sv
// brc_out_latch: one port's output data latch with selectable reset mode
// assumes global_set_reset_n and local_reset come from fabric logic
`timescale 1ns/1ps
module brc_out_latch (
  // clock and resets
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       global_set_reset_n,
  input  wire logic                       local_reset,
  // configuration
  input  wire logic                       async_mode,
  // data
  input  wire logic                       load,
  input  wire logic [brc_pkg::DATA_W-1:0] d,
  output logic      [brc_pkg::DATA_W-1:0] q
);

  logic async_clr;

  // global clear ignores the mode; local clear only when async selected
  assign async_clr = ~global_set_reset_n | (async_mode & local_reset); // RULE6

  always_ff @(posedge core_clk or posedge async_clr) begin
    if (async_clr) begin
      q <= '0; // RULE5
    end else if (rst || local_reset) begin
      q <= '0; // RULE3
    end else if (load) begin
      q <= d;
    end
  end

endmodule // brc_out_latch

// file: sim/brc_fabric_model.sv
// brc_fabric_model: fabric user logic beside the block ram
// assumes one free-running core_clk shared with the block
`timescale 1ns/1ps
module brc_fabric_model (
  // clock
  input  wire logic core_clk,
  // bench requests
  input  wire logic en_req,
  input  wire logic gsr_req,
  // towards the block
  output logic      clk_en,
  output logic      global_set_reset_n,
  output logic      busy
);
  logic hold;

  // enables forced low around the whole global reset
  assign clk_en = en_req & ~hold;

  initial begin
    hold = 1'b0;
    busy = 1'b0;
    global_set_reset_n = 1'b1;
    forever begin
      @(posedge core_clk);
      if (gsr_req) begin
        busy <= 1'b1;
        hold <= 1'b1;
        @(posedge core_clk);
        // clock steady a full period before the reset moves
        global_set_reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        global_set_reset_n <= 1'b1;
        @(posedge core_clk);
        hold <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule // brc_fabric_model

// file: sim/brc_top_tb_top.sv
// brc_top_tb_top: directed bench for the block ram reset control block
// assumes brc_fabric_model sequences the global reset and enables
`timescale 1ns/1ps
module brc_top_tb_top;
  logic        core_clk, rst, read_pointer_reset, port_a_output_reset;
  logic        port_b_output_reset, port_a_write_en, port_b_read_en;
  logic        en_req, gsr_req, clk_en, global_set_reset_n, busy;
  logic        fifo_empty, fifo_full, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] port_a_write_data, port_a_q, port_b_q, s_axi_wdata;
  logic [31:0] s_axi_rdata, d;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb;
  int          num_errors, tests_run;

  brc_top uut (.core_clk, .rst, .global_set_reset_n, .read_pointer_reset,
    .port_a_output_reset, .port_b_output_reset, .port_a_clk_en(clk_en),
    .port_a_write_en, .port_a_write_data, .port_a_q, .port_b_clk_en(clk_en),
    .port_b_read_en, .port_b_q, .fifo_empty, .fifo_full, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  brc_fabric_model fab (.core_clk, .en_req, .gsr_req, .clk_en,
    .global_set_reset_n, .busy);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic hang();
    num_errors++;
    stop_test();
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  // handshakes judged at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bh = 1'b0;
    for (int n = 0; n < 50 && !bh; n++) begin
      @(negedge core_clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
    end
    if (!bh) hang();
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ah, bh;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    bh = 1'b0;
    for (int n = 0; n < 50 && !bh; n++) begin
      @(negedge core_clk);
      ah = s_axi_arvalid & s_axi_arready;
      bh = s_axi_rvalid & s_axi_rready;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge core_clk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (bh) s_axi_rready <= 1'b0;
    end
    if (!bh) hang();
  endtask

  task automatic push(input int n, input logic [31:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      port_a_write_en <= 1'b1;
      port_a_write_data <= b + 32'(i);
    end
    @(posedge core_clk);
    port_a_write_en <= 1'b0;
    @(negedge core_clk);
  endtask

  // pops n words expecting b, b+1, ...
  task automatic pop(input int n, input logic [31:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      port_b_read_en <= 1'b1;
      @(negedge core_clk);
      if (i > 0) chk("port_b_q", b + 32'(i) - 1, port_b_q);
    end
    @(posedge core_clk);
    port_b_read_en <= 1'b0;
    @(negedge core_clk);
    chk("port_b_q", b + 32'(n) - 1, port_b_q);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("fifo_empty", 1, fifo_empty);
    chk("fifo_full", 0, fifo_full);
    chk("port_a_q", 0, port_a_q);
    chk("port_b_q", 0, port_b_q);
    axi_rd(brc_pkg::OFS_STATUS);
    chk("status", 32'h0001_0000, d);
    $display("test reset done");
  endtask

  task automatic t_regs();
    // low byte strobe off: the control bits must not move
    s_axi_wstrb <= 4'hE;
    axi_wr(brc_pkg::OFS_CTRL, 32'h3);
    s_axi_wstrb <= 4'hF;
    chk("bresp", brc_pkg::RESP_OKAY, r);
    axi_rd(brc_pkg::OFS_CTRL);
    chk("ctrl", 32'h0, d);
    axi_wr(brc_pkg::OFS_CTRL, 32'h3);
    chk("bresp", brc_pkg::RESP_OKAY, r);
    axi_rd(brc_pkg::OFS_CTRL);
    chk("ctrl", 32'h3, d);
    axi_rd(brc_pkg::OFS_STATUS);
    chk("status", 32'h000D_0000, d);
    axi_wr(brc_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    chk("bresp", brc_pkg::RESP_OKAY, r);
    axi_wr(8'h08, 32'h3);
    chk("bresp", brc_pkg::RESP_SLVERR, r);
    axi_rd(8'h08);
    chk("rresp", brc_pkg::RESP_SLVERR, r);
    axi_wr(brc_pkg::OFS_CTRL, 32'h0);
    $display("test regs done");
  endtask

  // one packet of three words, replayed after partial read
  task automatic t_replay();
    push(3, 32'h11);
    pop(2, 32'h11);
    @(posedge core_clk);
    read_pointer_reset <= 1'b1;
    @(posedge core_clk);
    read_pointer_reset <= 1'b0;
    axi_rd(brc_pkg::OFS_STATUS);
    chk("status", 32'h3, d);
    pop(3, 32'h11);
    chk("fifo_empty", 1, fifo_empty);
    axi_wr(brc_pkg::OFS_CTRL, 32'h4);
    pop(3, 32'h11);
    // pop straight after the pointer reset replays word zero
    @(posedge core_clk);
    read_pointer_reset <= 1'b1;
    @(posedge core_clk);
    read_pointer_reset <= 1'b0;
    port_b_read_en <= 1'b1;
    @(posedge core_clk);
    port_b_read_en <= 1'b0;
    @(negedge core_clk);
    chk("port_b_q", 32'h11, port_b_q);
    $display("test replay done");
  endtask

  task automatic t_wrap();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    push(256, 32'h100);
    chk("fifo_full", 1, fifo_full);
    axi_rd(brc_pkg::OFS_STATUS);
    chk("status", 32'h0002_0100, d);
    push(1, 32'hDEAD);
    pop(256, 32'h100);
    chk("fifo_empty", 1, fifo_empty);
    push(1, 32'hA5);
    chk("port_a_q", 32'h100, port_a_q);
    $display("test wrap done");
  endtask

  task automatic t_local();
    @(posedge core_clk);
    port_a_output_reset <= 1'b1;
    #1 chk("port_a_q", 32'h100, port_a_q);
    @(posedge core_clk);
    port_a_output_reset <= 1'b0;
    @(negedge core_clk);
    chk("port_a_q", 0, port_a_q);
    chk("port_b_q", 32'h1FF, port_b_q);
    axi_wr(brc_pkg::OFS_CTRL, 32'h2);
    @(posedge core_clk);
    port_b_output_reset <= 1'b1;
    #1 chk("port_b_q", 0, port_b_q);
    @(posedge core_clk);
    port_b_output_reset <= 1'b0;
    $display("test local done");
  endtask

  task automatic t_gsr();
    int n;
    push(1, 32'h77);
    pop(1, 32'hA5);
    chk("port_a_q", 32'h101, port_a_q);
    @(posedge core_clk);
    gsr_req <= 1'b1;
    @(posedge core_clk);
    gsr_req <= 1'b0;
    for (n = 0; n < 200 && global_set_reset_n; n++) #1;
    if (global_set_reset_n) hang();
    // no clock edge yet: only an asynchronous clear shows here
    #1 chk("port_a_q", 0, port_a_q);
    chk("port_b_q", 0, port_b_q);
    for (n = 0; n < 20 && busy; n++) @(posedge core_clk);
    if (busy) hang();
    pop(1, 32'h77);
    // async port a clear with a live word, port b must keep its word
    push(1, 32'h88);
    chk("port_a_q", 32'h102, port_a_q);
    axi_wr(brc_pkg::OFS_CTRL, 32'h1);
    @(posedge core_clk);
    port_a_output_reset <= 1'b1;
    #1 chk("port_a_q", 0, port_a_q);
    chk("port_b_q", 32'h77, port_b_q);
    @(posedge core_clk);
    port_a_output_reset <= 1'b0;
    $display("test gsr done");
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    en_req = 1'b1;
    s_axi_wstrb = 4'hF;
    {read_pointer_reset, port_a_output_reset, port_b_output_reset} = '0;
    {port_a_write_en, port_b_read_en, gsr_req, s_axi_awvalid} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {port_a_write_data, s_axi_wdata, s_axi_awaddr, s_axi_araddr} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    t_reset();
    t_regs();
    t_replay();
    t_wrap();
    t_local();
    t_gsr();
    stop_test();
  end
endmodule // brc_top_tb_top
